// *** rtl/nsr_regs_pkg.sv ***
// constants for the converter feature configuration registers
package requantizer_regs_pkg;
  localparam logic [7:0] ADDR_PATTERN_LOW  = 8'h1f;
  localparam logic [7:0] ADDR_PATTERN_HIGH = 8'h20;
  localparam logic [7:0] ADDR_REQ_CONTROL  = 8'h3c;
  localparam logic [7:0] ADDR_REQ_TUNING   = 8'h3e;
  localparam logic [7:0] RESET_PATTERN     = 8'h00;
  localparam logic [7:0] RESET_CONTROL     = 8'h00;
  localparam logic [5:0] RESET_TUNING      = 6'h1c;
  localparam int         ON_BIT            = 0;
  localparam int         MODE_LSB          = 1;
  localparam int         MODE_MSB          = 3;
  localparam int         TUNE_MSB          = 5;
  localparam logic [2:0] MODE_22_CODE      = 3'h0;
  localparam logic [2:0] MODE_33_CODE      = 3'h1;
  localparam logic [6:0] TUNE_COUNT_22     = 7'h39;
  localparam logic [6:0] TUNE_COUNT_33     = 7'h22;
  localparam logic [7:0] HALF_PCT_STEP     = 8'h05;
endpackage

// *** rtl/band_edge_calc.sv ***
// band position decode: tuning word to offset in tenths of a percent
`timescale 1ns/1ps
`default_nettype none
module band_edge_calc
  import requantizer_regs_pkg::*;
(
  input  wire logic [5:0] tune_i,       // tuning word
  input  wire logic [1:0] bw_i,         // 01 = 22 %, 10 = 33 %, 00 = reserved
  output logic      [9:0] offset_o,     // band start, 0.1 % units
  output logic            tune_ok_o     // word within legal count
);
  always_comb begin
    offset_o  = 10'(tune_i) * 10'(HALF_PCT_STEP);
    tune_ok_o = bw_i[0] ? (7'(tune_i) < TUNE_COUNT_22) :
                bw_i[1] ? (7'(tune_i) < TUNE_COUNT_33) : 1'b0;
  end
endmodule
`default_nettype wire

// *** rtl/noise_shaper_config_regs.sv ***
// register bank for test pattern four and the requantizer controls
`timescale 1ns/1ps
`default_nettype none
module noise_shaper_config_regs
  import requantizer_regs_pkg::*;
(
  input  wire logic        clk_i,         // serial port clock domain
  input  wire logic        rst_b_i,       // async reset, active low
  input  wire logic        wr_en_i,       // register write strobe
  input  wire logic        rd_en_i,       // register read strobe
  input  wire logic [7:0]  addr_i,        // register address
  input  wire logic [7:0]  wdata_i,       // write data
  output logic      [7:0]  rdata_o,       // registered read data
  output logic      [15:0] pattern_o,     // test pattern four
  output logic             req_on_o,      // requantizer engaged
  output logic             bw_22_o,       // 22 percent mode active
  output logic             bw_33_o,       // 33 percent mode active
  output logic      [5:0]  band_pos_o,    // tuning word
  output logic      [9:0]  band_offset_o, // band start, 0.1 percent units
  output logic             tune_ok_o      // tuning word legal for mode
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] pat_lo;
    logic [7:0] pat_hi;
    logic       on;
    logic [2:0] bw_sel;
    logic [5:0] band;
    logic [7:0] rdata;
  } regs_s;

  regs_s      st_r;
  regs_s      st_nxt;
  logic [1:0] bw_vec;

  // ****************************************
  // address map
  // ****************************************
  // true for the four mapped offsets; every other address reads zero and drops writes
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == ADDR_PATTERN_LOW) || (a == ADDR_PATTERN_HIGH) ||
                 (a == ADDR_REQ_CONTROL) || (a == ADDR_REQ_TUNING);
  endfunction

  // ****************************************
  // write and read decode
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (wr_en_i) begin
      case (addr_i)
        ADDR_PATTERN_LOW:  st_nxt.pat_lo = wdata_i;
        ADDR_PATTERN_HIGH: st_nxt.pat_hi = wdata_i;
        ADDR_REQ_CONTROL: begin
          st_nxt.on     = wdata_i[ON_BIT];
          st_nxt.bw_sel = wdata_i[MODE_MSB:MODE_LSB];
        end
        ADDR_REQ_TUNING:   st_nxt.band = wdata_i[TUNE_MSB:0];
        default: ;
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        ADDR_PATTERN_LOW:  st_nxt.rdata = st_r.pat_lo;
        ADDR_PATTERN_HIGH: st_nxt.rdata = st_r.pat_hi;
        ADDR_REQ_CONTROL:  st_nxt.rdata = {4'h0, st_r.bw_sel, st_r.on};
        ADDR_REQ_TUNING:   st_nxt.rdata = {2'h0, st_r.band};
        default:           st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.pat_lo <= RESET_PATTERN;
      st_r.pat_hi <= RESET_PATTERN;
      st_r.on     <= RESET_CONTROL[ON_BIT];
      st_r.bw_sel <= RESET_CONTROL[MODE_MSB:MODE_LSB];
      st_r.band   <= RESET_TUNING;
      st_r.rdata  <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // requantizer steering
  // ****************************************
  // a reserved mode code leaves the requantizer bypassed rather than guessing a band
  assign bw_vec[0] = (st_r.bw_sel == MODE_22_CODE);
  assign bw_vec[1] = (st_r.bw_sel == MODE_33_CODE);

  assign rdata_o    = st_r.rdata;
  assign pattern_o  = {st_r.pat_hi, st_r.pat_lo};
  assign req_on_o   = st_r.on & (bw_vec != 2'h0);
  assign bw_22_o    = bw_vec[0];
  assign bw_33_o    = bw_vec[1];
  assign band_pos_o = st_r.band;

  // legality only flagged; host must obey the word counts itself
  band_edge_calc u_edge (
    .tune_i    (st_r.band),
    .bw_i      (bw_vec),
    .offset_o  (band_offset_o),
    .tune_ok_o (tune_ok_o)
  );

  // ****************************************
  // checks
  // ****************************************
  a_pattern_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_PATTERN_HIGH |=> pattern_o[15:8] == $past(wdata_i))
    else $error("pattern high byte not stored");
  a_control_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && addr_i == ADDR_REQ_CONTROL |=> rdata_o[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
  a_tuning_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && !wr_en_i && addr_i == ADDR_REQ_TUNING |=> rdata_o == {2'h0, band_pos_o})
    else $error("tuning readback wrong");
  a_mode_22: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && wdata_i[3:1] == 3'h0 |=> bw_22_o && !bw_33_o)
    else $error("22 percent mode not selected");
  a_mode_33: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && wdata_i[3:1] == 3'h1 |=> bw_33_o && !bw_22_o)
    else $error("33 percent mode not selected");
  a_enable_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && wdata_i[3:0] == 4'h1 |=> req_on_o)
    else $error("requantizer not enabled");
  a_reserved_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && wdata_i[3:2] != 2'h0 |=> !req_on_o)
    else $error("reserved mode engaged requantizer");
  a_step_size: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    band_pos_o != 6'h00 && band_pos_o == $past(band_pos_o) + 6'h01
      |-> band_offset_o == $past(band_offset_o) + 10'h005)
    else $error("band step not half percent");

  // ****************************************
  // checks: storage and hold
  // ****************************************
  a_pattern_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_PATTERN_LOW |=> pattern_o[7:0] == $past(wdata_i))
    else $error("pattern low byte not stored");
  a_pattern_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(wr_en_i && (addr_i == ADDR_PATTERN_LOW || addr_i == ADDR_PATTERN_HIGH)) |=> $stable(pattern_o))
    else $error("pattern changed without a write");
  // first edge after release still shows the reset contents
  a_reset_values: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> pattern_o == 16'h0000 && !req_on_o && bw_22_o
      && band_pos_o == RESET_TUNING && rdata_o == 8'h00)
    else $error("register contents wrong after reset");
  a_enable_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && !wdata_i[0] |=> !req_on_o)
    else $error("requantizer left on after clear");
  a_enable_follows: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_CONTROL && wdata_i[3:1] == 3'h1 |=> req_on_o == $past(wdata_i[0]))
    else $error("enable bit not followed in 33 percent mode");
  a_control_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(wr_en_i && addr_i == ADDR_REQ_CONTROL) |=> $stable({req_on_o, bw_22_o, bw_33_o}))
    else $error("requantizer controls changed without a write");
  a_mode_exclusive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(bw_22_o && bw_33_o))
    else $error("both bandwidth modes active");
  a_on_needs_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    req_on_o |-> bw_22_o || bw_33_o)
    else $error("requantizer on in reserved mode");
  a_tuning_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && addr_i == ADDR_REQ_TUNING |=> band_pos_o == $past(wdata_i[5:0]))
    else $error("tuning word not stored");
  a_tuning_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(wr_en_i && addr_i == ADDR_REQ_TUNING) |=> $stable(band_pos_o))
    else $error("tuning word changed without a write");

  // ****************************************
  // checks: readback and reserved space
  // ****************************************
  a_pattern_low_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && addr_i == ADDR_PATTERN_LOW |=> rdata_o == $past(pattern_o[7:0]))
    else $error("pattern low readback wrong");
  a_pattern_high_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && addr_i == ADDR_PATTERN_HIGH |=> rdata_o == $past(pattern_o[15:8]))
    else $error("pattern high readback wrong");
  a_tuning_reserved: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && addr_i == ADDR_REQ_TUNING |=> rdata_o[7:6] == 2'h0)
    else $error("reserved tuning bits read nonzero");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_en_i && !reg_mapped(addr_i) |=> rdata_o == 8'h00)
    else $error("unmapped address read nonzero");
  a_unmapped_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_i && !reg_mapped(addr_i)
      |=> $stable(pattern_o) && $stable(band_pos_o) && $stable({req_on_o, bw_22_o, bw_33_o}))
    else $error("unmapped write changed a register");
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !rd_en_i |=> $stable(rdata_o))
    else $error("read data changed without a read");

  // ****************************************
  // checks: tuning legality and offset
  // ****************************************
  // the flag only reports; a host that ignores it still gets its word stored
  a_legal_22: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bw_22_o |-> tune_ok_o == (band_pos_o <= 6'h38))
    else $error("legality flag wrong in 22 percent mode");
  a_legal_33: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bw_33_o |-> tune_ok_o == (band_pos_o <= 6'h21))
    else $error("legality flag wrong in 33 percent mode");
  a_legal_reserved: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !bw_22_o && !bw_33_o |-> !tune_ok_o)
    else $error("legality flag set in reserved mode");
  a_offset_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    band_pos_o == 6'h00 |-> band_offset_o == 10'h000)
    else $error("band offset not zero for word zero");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
// host controller model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk_i,   // register clock
  output logic            wr_en_o, // write strobe
  output logic            rd_en_o, // read strobe
  output logic      [7:0] addr_o,  // address
  output logic      [7:0] wdata_o, // write data
  input  wire logic [7:0] rdata_i  // read data
);
  // address and data hold still while idle, so the port makes no noise
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // callers pass only legal tuning words for the active mode
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// *** bench/noise_shaper_config_regs_tb.sv ***
// self-checking bench for the requantizer configuration registers
`timescale 1ns/1ps
`default_nettype none
module noise_shaper_config_regs_tb;
  import requantizer_regs_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       wr_en, rd_en, req_on, bw_22, bw_33, tune_ok;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] pattern;
  logic [5:0] band_pos;
  logic [9:0] band_off;
  int         err_total = 0;
  int         compares = 0;
  initial forever #20 clk_i = ~clk_i;
  host_model host_u (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  noise_shaper_config_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .pattern_o(pattern), .req_on_o(req_on),
    .bw_22_o(bw_22), .bw_33_o(bw_33), .band_pos_o(band_pos), .band_offset_o(band_off), .tune_ok_o(tune_ok));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic test_reset();
    rchk(ADDR_PATTERN_LOW, 8'h00);
    rchk(ADDR_PATTERN_HIGH, 8'h00);
    rchk(ADDR_REQ_CONTROL, 8'h00);
    rchk(ADDR_REQ_TUNING, 8'h1c);
    chk({15'h0000, req_on}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic test_pattern();
    host_u.wr(ADDR_PATTERN_LOW, 8'ha5);
    host_u.wr(ADDR_PATTERN_HIGH, 8'h5a);
    chk(pattern, 16'h5aa5);
    rchk(ADDR_PATTERN_HIGH, 8'h5a);
    rchk(ADDR_PATTERN_LOW, 8'ha5);
    host_u.wr(8'h3d, 8'hff);
    rchk(8'h3d, 8'h00);
    chk(pattern, 16'h5aa5);
    $display("pattern test done");
  endtask
  task automatic test_modes();
    // every mode code, reserved high bits set to prove they are dropped
    for (int m = 0; m < 8; m++) begin
      host_u.wr(ADDR_REQ_CONTROL, {4'hf, m[2:0], 1'b1});
      chk({12'h000, req_on, bw_22, bw_33, tune_ok}, {12'h000, m < 2, m == 0, m == 1, m < 2});
      rchk(ADDR_REQ_CONTROL, {4'h0, m[2:0], 1'b1});
    end
    host_u.wr(ADDR_REQ_CONTROL, 8'h02);
    chk({15'h0000, req_on}, 16'h0000);
    $display("mode test done");
  endtask
  task automatic test_tuning();
    host_u.wr(ADDR_REQ_CONTROL, 8'h01);
    host_u.wr(ADDR_REQ_TUNING, 8'hf8);
    chk({band_off, band_pos}, {10'd280, 6'h38});
    chk({15'h0000, tune_ok}, 16'h0001);
    rchk(ADDR_REQ_TUNING, 8'h38);
    // consecutive words walk the band one half percent at a time
    for (int w = 0; w < 3; w++) begin
      host_u.wr(ADDR_REQ_TUNING, {2'h0, w[5:0]});
      chk({6'h00, band_off}, 16'(w * 5));
    end
    // a word legal in both modes goes in first, so no illegal pairing is programmed
    host_u.wr(ADDR_REQ_TUNING, 8'h21);
    host_u.wr(ADDR_REQ_CONTROL, 8'h03);
    chk({5'h00, tune_ok, band_off}, {5'h00, 1'b1, 10'd165});
    $display("tuning test done");
  endtask
  task automatic end_of_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    test_reset();
    test_pattern();
    test_modes();
    test_tuning();
    // reset in mid-run must restore every register
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    test_reset();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
